// ==== shadow_pkg.sv ====
// Constants shared by the register shadow bank
package shadow_pkg;
    // Command opcodes
    localparam logic [7:0] write_registers_cmd = 8'h01;
    localparam logic [7:0] read_any_reg_cmd = 8'h65;
    localparam logic [7:0] write_any_reg_cmd = 8'h71;
    localparam logic [7:0] write_enable_cmd = 8'h06;
    localparam logic [7:0] write_disable_cmd = 8'h04;
    // Register selectors for read/write any register
    localparam logic [2:0] sel_status_nv = 3'h0;
    localparam logic [2:0] sel_status_v = 3'h1;
    localparam logic [2:0] sel_pointer = 3'h2;
    localparam logic [2:0] sel_password = 3'h3;
    localparam logic [2:0] sel_region = 3'h4;
    // Status register 1 field positions
    localparam int reg_protect_pos = 7;
    localparam int granularity_pos = 6;
    localparam int top_bottom_pos = 5;
    localparam int block_protect_hi = 4;
    localparam int block_protect_lo = 2;
    localparam int write_latch_pos = 1;
    localparam int busy_flag_pos = 0;
    // Host-writable bits of status one (latch and busy are read only)
    localparam logic [7:0] status_user_mask = 8'hfc;
    // Shipped defaults
    localparam logic [7:0] status_nv_ship = 8'h00;
    localparam logic [31:0] pointer_ship = 32'hffffffff;
    localparam logic [63:0] password_ship = 64'hffffffffffffffff;
    localparam logic [15:0] region_ship = 16'hffff;
    // Non-volatile program time
    localparam int clk_mhz = 125;
    localparam int program_us = 5;
    localparam int program_cycles = program_us * clk_mhz;
    localparam int cnt_w = 16;
endpackage

// ==== nv_cell.sv ====
`timescale 1ns/1ns
// One non-volatile word: erase-and-program or OTP programming
module nv_cell #(
    parameter int width = 8,
    parameter logic [width-1:0] ship = '0,
    parameter bit otp = 1'b0
) (
    // Clock
    input wire logic clk_sys,
    input wire logic ce,
    // Program request
    input wire logic load,
    input wire logic [width-1:0] din,
    input wire logic [width-1:0] mask,
    // Contents
    output logic [width-1:0] q
);
    typedef struct packed {
        logic [width-1:0] q;
    } cell_t;
    // Shipped contents given at declaration, since no reset may touch them
    cell_t cur = '{q: ship};
    cell_t nxt;
    always_comb begin
        nxt = cur;
        if (load) begin
            // OTP bits only move from erased 1 to programmed 0
            if (otp)
                nxt.q = cur.q & ~(mask & ~din);
            else
                nxt.q = (cur.q & ~mask) | (din & mask);
        end
    end
    // No reset: contents survive every reset, like the cells they model
    always_ff @(posedge clk_sys) begin
        if (ce)
            cur <= nxt;
    end
    assign q = cur.q;
endmodule // nv_cell

// ==== program_timer.sv ====
`timescale 1ns/1ns
// Busy timer for a non-volatile program step
module program_timer (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    // Control
    input wire logic start,
    input wire logic [15:0] cycles,
    // Status
    output logic busy,
    output logic done
);
    typedef struct packed {
        logic [15:0] cnt;
        logic busy;
        logic done;
    } tmr_t;
    tmr_t cur;
    tmr_t nxt;
    always_comb begin
        nxt = cur;
        nxt.done = 1'b0;
        if (cur.busy) begin
            if (cur.cnt <= 16'h0001) begin
                nxt.busy = 1'b0;
                nxt.done = 1'b1;
            end else begin
                nxt.cnt = cur.cnt - 16'h0001;
            end
        end else if (start) begin
            nxt.busy = 1'b1;
            nxt.cnt = cycles;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (rst)
            cur <= '0;
        else if (ce)
            cur <= nxt;
    end
    assign busy = cur.busy;
    assign done = cur.done;
endmodule // program_timer

// ==== nv_volatile_status_shadow.sv ====
`timescale 1ns/1ns
// Status register shadow bank: non-volatile and volatile copies
module nv_volatile_status_shadow
    import shadow_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    // Command port from the serial front end
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_op,
    input wire logic [2:0] cmd_sel,
    input wire logic [63:0] cmd_data,
    input wire logic cmd_nv,
    // Read answer
    output logic rd_valid,
    output logic [63:0] rd_data,
    // Status
    output logic busy,
    output logic [7:0] status_one_working_copy,
    output logic [7:0] status_one_nonvolatile_defaults
);
    import shadow_pkg::*;

    typedef enum logic [1:0] {idle, programming, refresh} state_t;

    typedef struct packed {
        state_t state;
        logic [7:0] work;
        logic [7:0] pend;
        logic [2:0] sel;
        logic reload;
        logic rd_valid;
        logic [63:0] rd_data;
    } bank_t;

    bank_t cur;
    bank_t nxt;

    logic [7:0] stat_nv;
    logic [31:0] pointer_region_reg;
    logic [63:0] password_q;
    logic [15:0] region_protection_reg;
    logic tmr_busy;
    logic tmr_done;
    logic start_prog;
    logic [7:0] stat_prev;
    logic [63:0] load_mask;
    logic ld_stat;
    logic ld_ptr;
    logic ld_pw;
    logic ld_reg;
    logic is_write;
    logic nv_cmd;
    logic [63:0] cmd_hold;

    localparam logic [15:0] prog_cnt = 16'(program_cycles);

    assign is_write = cmd_valid && cur.state == idle && !tmr_busy
        && (cmd_op == write_registers_cmd || cmd_op == write_any_reg_cmd);
    // Write-registers targets the non-volatile status copy only when cmd_nv is set
    assign nv_cmd = (cmd_op == write_registers_cmd) ? cmd_nv
        : (cmd_sel != sel_status_v);

    // The program step fires after the timer, holding the old copy meanwhile
    assign ld_stat = tmr_done && cur.sel == sel_status_nv;
    assign ld_ptr = tmr_done && cur.sel == sel_pointer;
    assign ld_pw = tmr_done && cur.sel == sel_password;
    assign ld_reg = tmr_done && cur.sel == sel_region;
    assign load_mask = {64{1'b1}};

    nv_cell #(.width(8), .ship(status_nv_ship), .otp(1'b0)) u_stat (
        .clk_sys(clk_sys),
        .ce(ce),
        .load(ld_stat),
        .din(cur.pend & status_user_mask),
        .mask(status_user_mask),
        .q(stat_nv)
    );
    nv_cell #(.width(32), .ship(pointer_ship), .otp(1'b0)) u_ptr (
        .clk_sys(clk_sys),
        .ce(ce),
        .load(ld_ptr),
        .din(cmd_hold[31:0]),
        .mask(load_mask[31:0]),
        .q(pointer_region_reg)
    );
    nv_cell #(.width(64), .ship(password_ship), .otp(1'b1)) u_pw (
        .clk_sys(clk_sys),
        .ce(ce),
        .load(ld_pw),
        .din(cmd_hold),
        .mask(load_mask),
        .q(password_q)
    );
    nv_cell #(.width(16), .ship(region_ship), .otp(1'b1)) u_reg (
        .clk_sys(clk_sys),
        .ce(ce),
        .load(ld_reg),
        .din(cmd_hold[15:0]),
        .mask(load_mask[15:0]),
        .q(region_protection_reg)
    );

    program_timer u_tmr (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .start(start_prog),
        .cycles(prog_cnt),
        .busy(tmr_busy),
        .done(tmr_done)
    );

    // Wide payload held for the long non-volatile targets
    always_ff @(posedge clk_sys) begin
        if (rst)
            cmd_hold <= '0;
        else if (ce && is_write)
            cmd_hold <= cmd_data;
    end

    // Tracks the NV protect default to spot any change to it
    always_ff @(posedge clk_sys) begin
        if (ce)
            stat_prev <= stat_nv;
    end

    assign start_prog = is_write && nv_cmd;

    always_comb begin
        nxt = cur;
        nxt.rd_valid = 1'b0;
        nxt.reload = 1'b0;
        unique case (cur.state)
            idle: begin
                if (cmd_valid && cmd_op == read_any_reg_cmd) begin
                    nxt.rd_valid = 1'b1;
                    unique case (cmd_sel)
                        sel_status_v: nxt.rd_data = {56'h0, cur.work};
                        sel_status_nv: nxt.rd_data = {56'h0, stat_nv};
                        sel_pointer: nxt.rd_data = {32'h0, pointer_region_reg};
                        sel_password: nxt.rd_data = password_q;
                        sel_region: nxt.rd_data = {48'h0, region_protection_reg};
                        default: nxt.rd_data = '0;
                    endcase
                end else if (cmd_valid && cmd_op == write_enable_cmd) begin
                    nxt.work[write_latch_pos] = 1'b1;
                end else if (cmd_valid && cmd_op == write_disable_cmd) begin
                    nxt.work[write_latch_pos] = 1'b0;
                end else if (is_write && !nv_cmd) begin
                    // Only the host bits move; latch and busy stay
                    nxt.work = (cur.work & ~status_user_mask)
                        | (cmd_data[7:0] & status_user_mask);
                end else if (start_prog) begin
                    nxt.pend = cmd_data[7:0];
                    nxt.sel = (cmd_op == write_registers_cmd)
                        ? sel_status_nv : cmd_sel;
                    nxt.work[busy_flag_pos] = 1'b1;
                    nxt.state = programming;
                end
            end
            programming: begin
                // Old volatile bits stay until the program completes
                if (tmr_done)
                    nxt.state = refresh;
            end
            refresh: begin
                if (cur.sel == sel_status_nv) begin
                    nxt.work = (cur.work & ~status_user_mask)
                        | (stat_nv & status_user_mask);
                end
                // OTP targets have no volatile bits in this bank
                nxt.work[busy_flag_pos] = 1'b0;
                nxt.work[write_latch_pos] = 1'b0;
                nxt.state = idle;
            end
            default: nxt.state = idle;
        endcase
        if (stat_nv[reg_protect_pos] != stat_prev[reg_protect_pos])
            nxt.work[reg_protect_pos] = stat_nv[reg_protect_pos];
        // First cycle after reset copies the defaults in
        if (cur.reload)
            nxt.work = stat_nv;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cur.state <= idle;
            cur.pend <= '0;
            cur.sel <= '0;
            cur.reload <= 1'b1;
            cur.rd_valid <= 1'b0;
            cur.rd_data <= '0;
            cur.work <= '0;
        end else if (ce) begin
            cur <= nxt;
        end
    end

    assign rd_valid = cur.rd_valid;
    assign rd_data = cur.rd_data;
    assign busy = cur.state != idle;
    assign status_one_working_copy = cur.work;
    assign status_one_nonvolatile_defaults = stat_nv;
endmodule // nv_volatile_status_shadow

// ==== host_cmd_model.sv ====
// Host-side command driver for the status shadow bank
`timescale 1ns/1ns
module host_cmd_model
    import shadow_pkg::*;
(
    // Clock
    input wire logic clk_sys,
    // Command port toward the bank
    output logic cmd_valid,
    output logic [7:0] cmd_op,
    output logic [2:0] cmd_sel,
    output logic [63:0] cmd_data,
    output logic cmd_nv
);
    initial begin
        cmd_valid = 1'b0;
        cmd_op = 8'h00;
        cmd_sel = 3'h0;
        cmd_data = 64'h0;
        cmd_nv = 1'b0;
    end
    // One-cycle pulse; fields turn to garbage once released
    task automatic send(input logic [7:0] op, input logic [2:0] sel,
                        input logic [63:0] data, input logic nv);
        @(posedge clk_sys);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_sel <= sel;
        cmd_data <= data;
        cmd_nv <= nv;
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
        cmd_op <= ~op;
        cmd_sel <= ~sel;
        cmd_data <= ~data;
        cmd_nv <= ~nv;
    endtask
endmodule // host_cmd_model

// ==== nv_shadow_properties.sv ====
// Port assertions for the status shadow bank
`timescale 1ns/1ns
module nv_shadow_checker
    import shadow_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    // Command port
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_op,
    input wire logic [2:0] cmd_sel,
    input wire logic [63:0] cmd_data,
    input wire logic cmd_nv,
    // Answers and status
    input wire logic rd_valid,
    input wire logic [63:0] rd_data,
    input wire logic busy,
    input wire logic [7:0] status_one_working_copy,
    input wire logic [7:0] status_one_nonvolatile_defaults
);
    logic [7:0] w;
    logic [7:0] n;
    logic go;
    assign w = status_one_working_copy;
    assign n = status_one_nonvolatile_defaults;
    assign go = cmd_valid && ce && !busy;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    property p_rd_v;
        go && cmd_op == read_any_reg_cmd && cmd_sel == sel_status_v
            |=> rd_valid && rd_data == {56'h0, $past(w)};
    endproperty
    a_rd_v: assert property (p_rd_v)
        else $error("status read lost working copy");
    property p_rd_nv;
        go && cmd_op == read_any_reg_cmd && cmd_sel == sel_status_nv
            |=> rd_valid && rd_data[7:0] == $past(n);
    endproperty
    a_rd_nv: assert property (p_rd_nv)
        else $error("nv status read wrong");
    property p_vwr;
        go && cmd_op == write_registers_cmd && !cmd_nv |=>
            w == {$past(cmd_data[7:2]), $past(w[1:0])} && $stable(n);
    endproperty
    a_vwr: assert property (p_vwr)
        else $error("volatile write wrong");
    property p_nvwr;
        go && cmd_op == write_any_reg_cmd && cmd_sel == sel_status_nv
            |=> busy;
    endproperty
    a_nvwr: assert property (p_nvwr)
        else $error("nv write did not start");
    property p_hold;
        busy && $past(busy) |-> $stable(w[7:2]);
    endproperty
    a_hold: assert property (p_hold)
        else $error("working copy moved during program");
    property p_ro;
        n[1:0] == 2'b00;
    endproperty
    a_ro: assert property (p_ro)
        else $error("read-only default bits changed");
    property p_refresh;
        $fell(busy) |-> w == {n[7:2], 2'b00};
    endproperty
    a_refresh: assert property (p_refresh)
        else $error("no refresh after program");
    property p_follow;
        $changed(n[7]) |=> w[7] == $past(n[7]);
    endproperty
    a_follow: assert property (p_follow)
        else $error("protect bit did not follow its default");
    property p_reload;
        $fell(rst) && ce |-> ##2 w == n;
    endproperty
    a_reload: assert property (p_reload)
        else $error("no reload after reset");
    c_prog: cover property ($fell(busy));
    c_read: cover property (rd_valid);
    c_reset: cover property ($fell(rst));
endmodule // nv_shadow_checker
bind nv_volatile_status_shadow nv_shadow_checker chk_u (
    .clk_sys(clk_sys), .rst(rst), .ce(ce), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_sel(cmd_sel), .cmd_data(cmd_data),
    .cmd_nv(cmd_nv), .rd_valid(rd_valid), .rd_data(rd_data), .busy(busy),
    .status_one_working_copy(status_one_working_copy),
    .status_one_nonvolatile_defaults(status_one_nonvolatile_defaults));

// ==== nv_volatile_status_shadow_bench.sv ====
// Self-checking bench for the status shadow bank
`timescale 1ns/1ns
module nv_volatile_status_shadow_bench;
    import shadow_pkg::*;
    typedef struct packed {
        logic [7:0] op;
        logic [2:0] sel;
        logic [7:0] data;
        logic nv;
        logic [7:0] exp;
    } row_t;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic cmd_valid;
    logic [7:0] cmd_op;
    logic [2:0] cmd_sel;
    logic [63:0] cmd_data;
    logic cmd_nv;
    logic rd_valid;
    logic [63:0] rd_data;
    logic busy;
    logic [7:0] wk;
    logic [7:0] nvc;
    int err_count = 0;
    int tests_run = 0;
    int cycles = 0;
    row_t rows [5];
    always #4 clk_sys = ~clk_sys;
    host_cmd_model host_u (.clk_sys(clk_sys), .cmd_valid(cmd_valid),
        .cmd_op(cmd_op), .cmd_sel(cmd_sel), .cmd_data(cmd_data),
        .cmd_nv(cmd_nv));
    nv_volatile_status_shadow dut_u (.clk_sys(clk_sys), .rst(rst),
        .ce(ce), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_sel(cmd_sel), .cmd_data(cmd_data), .cmd_nv(cmd_nv),
        .rd_valid(rd_valid), .rd_data(rd_data), .busy(busy),
        .status_one_working_copy(wk),
        .status_one_nonvolatile_defaults(nvc));
    task automatic check(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    task automatic rd(input logic [2:0] sel, output logic [63:0] v);
        host_u.send(read_any_reg_cmd, sel, 64'h0, 1'b0);
        #1;
        v = (rd_valid === 1'b1) ? rd_data : 'x;
    endtask
    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Ceiling well above the roughly 1330 cycles the run needs
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            err_count++;
            $display("unexpected at %0t: run too long", $time);
            wrap_up;
        end
    end
    initial begin
        logic [63:0] v;
        row_t r;
        rows[0] = '{write_registers_cmd, sel_status_v, 8'hff, 1'b0, 8'hfc};
        rows[1] = '{write_enable_cmd, sel_status_v, 8'h00, 1'b0, 8'hfe};
        rows[2] = '{write_any_reg_cmd, sel_status_v, 8'h00, 1'b0, 8'h02};
        rows[3] = '{write_disable_cmd, sel_status_v, 8'h00, 1'b0, 8'h00};
        rows[4] = '{write_registers_cmd, sel_status_v, 8'ha8, 1'b0, 8'ha8};
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        check(nvc === status_nv_ship, "nv ship");
        check(nvc[5:2] === status_nv_ship[5:2], "bp ship");
        check(wk === 8'h00, "working after power-up");
        $display("test power-up done");
        foreach (rows[i]) begin
            r = rows[i];
            host_u.send(r.op, r.sel, {56'h0, r.data}, r.nv);
            rd(sel_status_v, v);
            check(v === {56'h0, r.exp}, "work");
            rd(sel_status_nv, v);
            check(v === 64'h0, "nv copy touched");
        end
        $display("test table done");
        rd(sel_pointer, v);
        check(v === {32'h0, pointer_ship}, "pointer");
        rd(sel_password, v);
        check(v === password_ship, "password");
        rd(sel_region, v);
        check(v === {48'h0, region_ship}, "region");
        $display("test wide registers done");
        // Clock enable low: the one-cycle command must be lost
        @(posedge clk_sys);
        ce <= 1'b0;
        host_u.send(write_registers_cmd, sel_status_v, 64'h54, 1'b0);
        ce <= 1'b1;
        #1;
        check(wk === 8'ha8, "write taken while frozen");
        $display("test clock enable done");
        host_u.send(write_any_reg_cmd, sel_status_nv, 64'hb7, 1'b0);
        #1;
        check(busy === 1'b1, "busy after nv write");
        check(wk === 8'ha9, "working held");
        // Refused: the bank is still programming
        host_u.send(write_registers_cmd, sel_status_v, 64'h0, 1'b0);
        repeat (100) @(posedge clk_sys);
        #1;
        check(wk === 8'ha9, "write during busy");
        for (int i = 0; i < 1000 && busy !== 1'b0; i++) begin
            @(posedge clk_sys);
            #1;
        end
        check(nvc === 8'hb4, "nv programmed");
        check(wk === 8'hb4, "refreshed");
        $display("test nv write done");
        host_u.send(write_any_reg_cmd, sel_region, 64'h00f0, 1'b0);
        #1;
        check(busy === 1'b1, "busy after otp write");
        for (int i = 0; i < 1000 && busy !== 1'b0; i++) begin
            @(posedge clk_sys);
            #1;
        end
        rd(sel_region, v);
        check(v === 64'h00f0, "otp programmed");
        check(wk === 8'hb4, "otp left working copy");
        $display("test otp done");
        host_u.send(write_registers_cmd, sel_status_v, 64'h0c, 1'b0);
        #1;
        check(wk === 8'h0c, "volatile write before reset");
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        check(wk === 8'hb4, "reload on reset");
        $display("test reset done");
        wrap_up;
    end
endmodule // nv_volatile_status_shadow_bench
